/* File: hw/burst2_cfg.svh */
// constants for the two-word-burst sram front end
`ifndef BURST2_CFG_SVH
`define BURST2_CFG_SVH
`define DQ_W 36
`define ADDR_W 22
`define LANE_W 9
`define NIB_W 4
`define LANES 4
`define NIBBLES 2
`define DW_X8 8
`define DW_X9 9
`define DW_X18 18
`define MEM_AW 4
`define MEM_WORDS 16
`define DQ_RST 36'h0_0000_0000
`define ADDR_RST 22'h00_0000
`endif

/* File: hw/burst2_pkg.sv */
// types shared by the two-word-burst sram front end
package burst2_pkg;
  // data width variant strapped on the part
  typedef enum logic [1:0] {VAR_X8, VAR_X9, VAR_X18, VAR_X36} width_variant_t;
  // write burst progress
  typedef enum logic [1:0] {WR_IDLE, WR_BEAT0, WR_BEAT1} wr_state_t;
  // read burst progress
  typedef enum logic [2:0] {RD_IDLE, RD_SKIP, RD_BEAT0, RD_BEAT1, RD_TAIL} rd_state_t;
  // every pin sampled into the clk_in domain
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic load_n;
    logic rnw;
    logic [21:0] addr;
    logic [1:0] nws_n;
    logic [3:0] bws_n;
    logic [35:0] dq;
    logic dll_off_n;
    logic single_clk;
    width_variant_t variant;
  } pin_t;
  // a loaded address waiting for or in its burst
  typedef struct packed {
    logic vld;
    logic [21:0] addr;
  } cmd_t;
endpackage

/* File: hw/burst2_sram_host_port.sv */
// command, address and write-mask front end of a two-word-burst ddr sram
`timescale 1ns/1ps
`include "burst2_cfg.svh"
module burst2_sram_host_port (
  // system clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // input and output clock pairs from the controller
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic c_in,
  input wire logic c_n_in,
  // command and shared address
  input wire logic load_strobe_n_in,
  input wire logic read_not_write_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  // write selects and write data
  input wire logic [`NIBBLES-1:0] nibble_write_sel_n_in,
  input wire logic [`LANES-1:0] byte_write_sel_n_in,
  input wire logic [`DQ_W-1:0] dq_in,
  // mode straps
  input wire logic dll_off_n_in,
  input wire logic single_clk_in,
  input wire logic [1:0] variant_in,
  // read data and echo clocks
  output logic [`DQ_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic echo_clock_out,
  output logic echo_clock_n_out
);

  // pin sampling stages
  burst2_pkg::pin_t pins_raw;
  burst2_pkg::pin_t pins_s1_reg;
  burst2_pkg::pin_t pins_reg;
  logic [3:0] clk_prev_reg;

  // gather every pin into one word
  assign pins_raw.k = k_in;
  assign pins_raw.k_n = k_n_in;
  assign pins_raw.c = c_in;
  assign pins_raw.c_n = c_n_in;
  assign pins_raw.load_n = load_strobe_n_in;
  assign pins_raw.rnw = read_not_write_in;
  assign pins_raw.addr = addr_in;
  assign pins_raw.nws_n = nibble_write_sel_n_in;
  assign pins_raw.bws_n = byte_write_sel_n_in;
  assign pins_raw.dq = dq_in;
  assign pins_raw.dll_off_n = dll_off_n_in;
  assign pins_raw.single_clk = single_clk_in;
  assign pins_raw.variant = burst2_pkg::width_variant_t'(variant_in);

  // two-stage synchroniser, all pins delayed alike
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pins_s1_reg <= '0;
      pins_reg <= '0;
    end
    else
    begin
      pins_s1_reg <= pins_raw;
      pins_reg <= pins_s1_reg;
    end
  end

  // third stage on the clocks only, for edge finding
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      clk_prev_reg <= 4'h0;
    else
      clk_prev_reg <= {pins_reg.k, pins_reg.k_n, pins_reg.c, pins_reg.c_n};
  end

  // clock edges and modes
  logic k_rise;
  logic k_n_rise;
  logic c_rise;
  logic c_n_rise;
  logic single_mode;
  logic dll_on;
  logic oc_true_rise;
  logic oc_comp_rise;
  burst2_pkg::width_variant_t variant;
  assign k_rise = pins_reg.k & ~clk_prev_reg[3];
  assign k_n_rise = pins_reg.k_n & ~clk_prev_reg[2];
  assign c_rise = pins_reg.c & ~clk_prev_reg[1];
  assign c_n_rise = pins_reg.c_n & ~clk_prev_reg[0];
  assign single_mode = pins_reg.single_clk;
  assign dll_on = pins_reg.dll_off_n;
  assign variant = pins_reg.variant;
  // output timing pair: c pair, or k pair in single-clock mode
  assign oc_true_rise = single_mode ? k_rise : c_rise;
  assign oc_comp_rise = single_mode ? k_n_rise : c_n_rise;

  // command decode, only on a true input clock rise
  logic load;
  logic wr_load;
  logic rd_load;
  assign load = k_rise & ~pins_reg.load_n;
  assign wr_load = load & ~pins_reg.rnw;
  assign rd_load = load & pins_reg.rnw;

  // word index from loaded address and beat number
  function automatic logic [`MEM_AW-1:0] word_index(
    input burst2_pkg::width_variant_t v,
    input logic [`ADDR_W-1:0] a,
    input logic beat
  );
    logic [`ADDR_W:0] w;
    w = {a, beat};
    if (v == burst2_pkg::VAR_X18)
      w = {1'b0, a[`ADDR_W-1:1], a[0] ^ beat};
    else if (v == burst2_pkg::VAR_X36)
      w = {2'b00, a[`ADDR_W-2:1], a[0] ^ beat};
    return w[`MEM_AW-1:0];
  endfunction

  // storage array
  logic [`DQ_W-1:0] mem [`MEM_WORDS];

  // write burst state
  burst2_pkg::wr_state_t wr_state_reg;
  burst2_pkg::wr_state_t wr_state_next;
  burst2_pkg::cmd_t wr_cmd_reg;
  burst2_pkg::cmd_t wr_cmd_next;
  burst2_pkg::cmd_t wr_pend_reg;
  burst2_pkg::cmd_t wr_pend_next;

  // write beat capture points
  logic wr_take0;
  logic wr_take1;
  logic wr_take;
  logic [`MEM_AW-1:0] wr_idx;
  logic [`DQ_W-1:0] wr_en;
  logic [`DQ_W-1:0] wr_word;
  assign wr_take0 = (wr_state_reg == burst2_pkg::WR_BEAT0) & k_rise;
  assign wr_take1 = (wr_state_reg == burst2_pkg::WR_BEAT1) & k_n_rise;
  assign wr_take = wr_take0 | wr_take1;
  assign wr_idx = word_index(variant, wr_cmd_reg.addr, wr_take1);

  // per-bit write enable from nibble or byte selects of this beat
  for (genvar i = 0; i < `DQ_W; i++)
  begin : g_bit
    localparam int LANE = i / `LANE_W;
    localparam int NIB = (i / `NIB_W) % `NIBBLES;
    logic lane_sel;
    logic nib_sel;
    assign lane_sel = ~pins_reg.bws_n[LANE];
    assign nib_sel = ~pins_reg.nws_n[NIB];
    assign wr_en[i] = (variant == burst2_pkg::VAR_X8) ? ((i < `DW_X8) && nib_sel) :
                      (variant == burst2_pkg::VAR_X9) ? ((i < `DW_X9) && lane_sel) :
                      (variant == burst2_pkg::VAR_X18) ? ((i < `DW_X18) && lane_sel) :
                      lane_sel;
  end

  // deselected lanes keep the stored bits
  assign wr_word = (mem[wr_idx] & ~wr_en) | (pins_reg.dq & wr_en);

  // write next state
  always_comb
  begin
    wr_state_next = wr_state_reg;
    wr_cmd_next = wr_cmd_reg;
    wr_pend_next = wr_pend_reg;
    unique case (wr_state_reg)
      burst2_pkg::WR_IDLE:
      begin
        if (wr_load)
        begin
          wr_state_next = burst2_pkg::WR_BEAT0;
          wr_cmd_next = '{vld: 1'b1, addr: pins_reg.addr};
        end
      end
      burst2_pkg::WR_BEAT0:
      begin
        if (k_rise)
          wr_state_next = burst2_pkg::WR_BEAT1;
      end
      burst2_pkg::WR_BEAT1:
      begin
        if (k_n_rise)
        begin
          wr_state_next = wr_pend_reg.vld ? burst2_pkg::WR_BEAT0 : burst2_pkg::WR_IDLE;
          wr_cmd_next = wr_pend_reg;
          wr_pend_next.vld = 1'b0;
        end
      end
    endcase
    // a write loaded mid-burst waits its turn
    if (wr_load && (wr_state_reg != burst2_pkg::WR_IDLE))
      wr_pend_next = '{vld: 1'b1, addr: pins_reg.addr};
  end

  // write state registers
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_state_reg <= burst2_pkg::WR_IDLE;
      wr_cmd_reg <= '{vld: 1'b0, addr: `ADDR_RST};
      wr_pend_reg <= '{vld: 1'b0, addr: `ADDR_RST};
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      wr_cmd_reg <= wr_cmd_next;
      wr_pend_reg <= wr_pend_next;
    end
  end

  // array write, one beat at a time
  always_ff @(posedge clk_in)
  begin
    if (wr_take)
      mem[wr_idx] <= wr_word;
  end

  // read burst state
  burst2_pkg::rd_state_t rd_state_reg;
  burst2_pkg::rd_state_t rd_state_next;
  burst2_pkg::cmd_t rd_cmd_reg;
  burst2_pkg::cmd_t rd_cmd_next;
  burst2_pkg::cmd_t rd_pend_reg;
  burst2_pkg::cmd_t rd_pend_next;

  // launch edges: dll on puts beat 0 on the complement edge
  logic rd_edge0;
  logic rd_edge1;
  logic rd_any_edge;
  logic rd_launch0;
  logic rd_launch1;
  logic rd_launch;
  logic rd_release;
  logic [`MEM_AW-1:0] rd_idx;
  burst2_pkg::rd_state_t rd_first;
  assign rd_edge0 = dll_on ? oc_comp_rise : oc_true_rise;
  assign rd_edge1 = dll_on ? oc_true_rise : oc_comp_rise;
  assign rd_any_edge = oc_true_rise | oc_comp_rise;
  assign rd_launch0 = (rd_state_reg == burst2_pkg::RD_BEAT0) & rd_edge0;
  assign rd_launch1 = (rd_state_reg == burst2_pkg::RD_BEAT1) & rd_edge1;
  assign rd_launch = rd_launch0 | rd_launch1;
  assign rd_release = (rd_state_reg == burst2_pkg::RD_TAIL) & rd_any_edge;
  assign rd_idx = word_index(variant, rd_cmd_reg.addr, rd_launch1);
  assign rd_first = dll_on ? burst2_pkg::RD_SKIP : burst2_pkg::RD_BEAT0;

  // read next state
  always_comb
  begin
    rd_state_next = rd_state_reg;
    rd_cmd_next = rd_cmd_reg;
    rd_pend_next = rd_pend_reg;
    unique case (rd_state_reg)
      burst2_pkg::RD_IDLE:
      begin
        if (rd_load)
        begin
          rd_state_next = rd_first;
          rd_cmd_next = '{vld: 1'b1, addr: pins_reg.addr};
        end
      end
      burst2_pkg::RD_SKIP:
      begin
        if (oc_true_rise)
          rd_state_next = burst2_pkg::RD_BEAT0;
      end
      burst2_pkg::RD_BEAT0:
      begin
        if (rd_edge0)
          rd_state_next = burst2_pkg::RD_BEAT1;
      end
      burst2_pkg::RD_BEAT1:
      begin
        if (rd_edge1)
          rd_state_next = burst2_pkg::RD_TAIL;
      end
      burst2_pkg::RD_TAIL:
      begin
        if (rd_any_edge)
        begin
          rd_state_next = rd_pend_reg.vld ? rd_first : burst2_pkg::RD_IDLE;
          rd_cmd_next = rd_pend_reg;
          rd_pend_next.vld = 1'b0;
        end
      end
    endcase
    // a read loaded mid-burst waits its turn; one loaded as RD_TAIL ends with none pending waits for a later read
    if (rd_load && (rd_state_reg != burst2_pkg::RD_IDLE))
      rd_pend_next = '{vld: 1'b1, addr: pins_reg.addr};
  end

  // read state registers
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rd_state_reg <= burst2_pkg::RD_IDLE;
      rd_cmd_reg <= '{vld: 1'b0, addr: `ADDR_RST};
      rd_pend_reg <= '{vld: 1'b0, addr: `ADDR_RST};
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      rd_cmd_reg <= rd_cmd_next;
      rd_pend_reg <= rd_pend_next;
    end
  end

  // read data and output enable registers
  logic [`DQ_W-1:0] dq_reg;
  logic oe_n_reg;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      dq_reg <= `DQ_RST;
      oe_n_reg <= 1'b1;
    end
    else
    begin
      if (rd_launch)
        dq_reg <= mem[rd_idx];
      if (rd_launch)
        oe_n_reg <= 1'b0;
      else if (rd_release)
        oe_n_reg <= 1'b1;
    end
  end

  // echo clocks follow the output clock pair
  logic echo_reg;
  logic echo_n_reg;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      echo_reg <= 1'b0;
      echo_n_reg <= 1'b0;
    end
    else
    begin
      echo_reg <= single_mode ? pins_reg.k : pins_reg.c;
      echo_n_reg <= single_mode ? pins_reg.k_n : pins_reg.c_n;
    end
  end

  // outputs
  assign dq_out = dq_reg;
  assign dq_oe_n_out = oe_n_reg;
  assign echo_clock_out = echo_reg;
  assign echo_clock_n_out = echo_n_reg;

endmodule

/* File: test/burst2_ctrl_model.sv */
// controller model: clock pairs plus command and data beats
`timescale 1ns/1ps
module burst2_ctrl_model (
  // system clock
  input wire logic clk_in,
  // pins toward the sram
  output logic k_out,
  output logic k_n_out,
  output logic c_out,
  output logic c_n_out,
  output logic load_strobe_n_out,
  output logic read_not_write_out,
  output logic [21:0] addr_out,
  output logic [1:0] nibble_write_sel_n_out,
  output logic [3:0] byte_write_sel_n_out,
  output logic [35:0] dq_out
);
  logic [2:0] phase_reg;
  // puts that never found their phase
  int put_miss = 0;
  // idle pins at time zero
  initial
  begin
    phase_reg = 3'h0;
    c_out = 1'b1;
    c_n_out = 1'b0;
    load_strobe_n_out = 1'b1;
    read_not_write_out = 1'b1;
    addr_out = 22'h00_0000;
    nibble_write_sel_n_out = 2'h3;
    byte_write_sel_n_out = 4'hf;
    dq_out = 36'h0_0000_0000;
  end
  // free running input pair, 8 cycles a period; output pair skewed one cycle late
  always @(negedge clk_in)
  begin
    phase_reg <= phase_reg + 3'h1;
    c_out <= k_out;
    c_n_out <= k_n_out;
  end
  assign k_out = !phase_reg[2];
  assign k_n_out = phase_reg[2];
  // one command or beat, changed one cycle before the clock rise it meets
  task automatic put(input logic [2:0] ph, input logic ld, rw, input logic [21:0] a,
    input logic [3:0] m, input logic [35:0] d);
    @(negedge clk_in);
    repeat (8)
      if (phase_reg != ph)
        @(negedge clk_in);
    if (phase_reg != ph)
      put_miss++;
    load_strobe_n_out = ld;
    read_not_write_out = rw;
    addr_out = a;
    byte_write_sel_n_out = m;
    nibble_write_sel_n_out = m[1:0];
    dq_out = d;
  endtask
endmodule

/* File: test/burst2_sram_host_port_bench.sv */
// self-checking bench for the two-word-burst sram front end
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module burst2_sram_host_port_bench;
  localparam logic [35:0] W0 = 36'h1_2345_6789;
  localparam logic [35:0] W1 = 36'h9_8765_4321;
  localparam logic [35:0] N0 = 36'h0_ff00_ff00;
  localparam logic [35:0] N1 = 36'h5_5555_5555;
  localparam logic [35:0] ALL = 36'hf_ffff_ffff;
  logic clk_in, nrst_in, k_in, k_n_in, c_in, c_n_in, load_n, rnw, dll_off_n, single;
  logic [21:0] addr;
  logic [1:0] nws_n, variant;
  logic [3:0] bws_n;
  logic [35:0] dq_in, dq_out;
  logic dq_oe_n_out;
  int n_mismatch = 0;
  int total_checks = 0;
  burst2_ctrl_model i_ctrl (.clk_in(clk_in), .k_out(k_in), .k_n_out(k_n_in), .c_out(c_in),
    .c_n_out(c_n_in), .load_strobe_n_out(load_n), .read_not_write_out(rnw), .addr_out(addr),
    .nibble_write_sel_n_out(nws_n), .byte_write_sel_n_out(bws_n), .dq_out(dq_in));
  burst2_sram_host_port i_burst2_sram_host_port (.clk_in(clk_in), .nrst_in(nrst_in),
    .k_in(k_in), .k_n_in(k_n_in), .c_in(c_in), .c_n_in(c_n_in), .load_strobe_n_in(load_n),
    .read_not_write_in(rnw), .addr_in(addr), .nibble_write_sel_n_in(nws_n),
    .byte_write_sel_n_in(bws_n), .dq_in(dq_in), .dll_off_n_in(dll_off_n),
    .single_clk_in(single), .variant_in(variant), .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out), .echo_clock_out(), .echo_clock_n_out());
  task automatic report_and_stop();
    n_mismatch += i_ctrl.put_miss;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [35:0] merge(input logic [35:0] old, nw, input logic [3:0] m);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (!m[i])
        merge[i*9 +: 9] = nw[i*9 +: 9];
  endfunction
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (dq_oe_n_out !== lvl && n < 60)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n == 60)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // load write, beat0 at next true rise, beat1 at the comp rise after
  task automatic wr(input logic [21:0] a, input logic [3:0] m0, m1, input logic [35:0] d0, d1);
    i_ctrl.put(3'h6, 1'b0, 1'b0, a, 4'hf, ~d1);
    i_ctrl.put(3'h6, 1'b1, 1'b1, ~a, m0, d0);
    i_ctrl.put(3'h2, 1'b1, 1'b1, ~a, m1, d1);
    i_ctrl.put(3'h6, 1'b1, 1'b0, a, 4'h0, ~d1);
  endtask
  // load read, then judge both words and the release
  task automatic rd(input logic [21:0] a, input logic [35:0] msk, e0, e1);
    i_ctrl.put(3'h6, 1'b0, 1'b1, a, 4'hf, 36'h0_0000_0000);
    i_ctrl.put(3'h6, 1'b1, 1'b0, ~a, 4'h0, 36'h0_0000_0000);
    wait_oe(1'b0);
    `CHK(dq_out & msk, e0 & msk)
    repeat (4) @(negedge clk_in);
    `CHK(dq_out & msk, e1 & msk)
    wait_oe(1'b1);
  endtask
  // x36 burst from an odd start walks to the even word
  task automatic burst_order();
    wr(22'h20_0005, 4'h0, 4'h0, W0, W1);
    rd(22'h00_0004, ALL, W1, W0);
  endtask
  // per-lane byte selects on both beats
  task automatic byte_masks();
    wr(22'h00_0004, 4'ha, 4'h5, N0, N1);
    rd(22'h00_0004, ALL, merge(W1, N0, 4'ha), merge(W0, N1, 4'h5));
  endtask
  // x8 nibble selects, burst always starts at the even word
  task automatic nibble_masks();
    variant = 2'h0;
    wr(22'h00_0003, 4'h0, 4'h0, 36'h0_0000_00a5, 36'h0_0000_003c);
    wr(22'h00_0003, 4'hd, 4'he, 36'h0_0000_0077, 36'h0_0000_0099);
    rd(22'h00_0003, 36'h0_0000_00ff, 36'h0_0000_0075, 36'h0_0000_0039);
    variant = 2'h3;
  endtask
  // x9 writes lane 0 only, burst index starts at zero
  task automatic x9_lane();
    variant = 2'h1;
    wr(22'h00_0005, 4'h0, 4'h0, W0, W1);
    wr(22'h00_0005, 4'h0, 4'hf, N0, N1);
    rd(22'h00_0005, 36'h0_0000_01ff, N0, W1);
    variant = 2'h3;
  endtask
  // x18 keeps lanes 2 and 3, address bit 0 seeds the burst
  task automatic x18_lanes();
    wr(22'h00_0008, 4'h0, 4'h0, ALL, ALL);
    variant = 2'h2;
    wr(22'h00_0009, 4'h0, 4'h0, W0, W1);
    variant = 2'h3;
    rd(22'h00_0008, ALL, merge(ALL, W1, 4'hc), merge(ALL, W0, 4'hc));
  endtask
  // strobe high with a read look, then a write look: no drive and no store
  task automatic load_high_ignored();
    int lows;
    lows = 0;
    i_ctrl.put(3'h6, 1'b1, 1'b1, 22'h00_0004, 4'hf, 36'h0_0000_0000);
    repeat (24)
    begin
      @(negedge clk_in);
      if (dq_oe_n_out !== 1'b1)
        lows++;
    end
    `CHK(lows, 0)
    i_ctrl.put(3'h6, 1'b1, 1'b0, 22'h00_0004, 4'h0, ALL);
    repeat (24)
      @(negedge clk_in);
  endtask
  // dll on with the skewed output pair timing the read
  task automatic dll_on_read();
    dll_off_n = 1'b1;
    single = 1'b0;
    rd(22'h00_0004, ALL, merge(W1, N0, 4'ha), merge(W0, N1, 4'h5));
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    nrst_in = 1'b0;
    variant = 2'h3;
    dll_off_n = 1'b0;
    single = 1'b1;
    repeat (5) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    burst_order();
    byte_masks();
    nibble_masks();
    x9_lane();
    x18_lanes();
    load_high_ignored();
    dll_on_read();
    report_and_stop();
  end
endmodule

/* File: test/burst2_sram_host_port_sva.sv */
// concurrent checks on the pins of the two-word-burst sram front end
`timescale 1ns/1ps
`include "burst2_cfg.svh"
module burst2_sram_host_port_sva (
  // watched pins
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic c_in,
  input wire logic c_n_in,
  input wire logic load_strobe_n_in,
  input wire logic read_not_write_in,
  input wire logic [`LANES-1:0] byte_write_sel_n_in,
  input wire logic single_clk_in,
  input wire logic [`DQ_W-1:0] dq_out,
  input wire logic dq_oe_n_out,
  input wire logic echo_clock_out,
  input wire logic echo_clock_n_out
);
  logic k_prev_reg;
  logic [5:0] rd_age_reg;
  logic [2:0] up_cnt_reg;
  logic rd_load;
  logic wr_load;
  logic echo_src;
  logic echo_src_n;
  // load detection at a true input clock rise, echo source select
  assign rd_load = k_in && !k_prev_reg && !load_strobe_n_in && read_not_write_in;
  assign wr_load = k_in && !k_prev_reg && !load_strobe_n_in && !read_not_write_in;
  assign echo_src = single_clk_in ? k_in : c_in;
  assign echo_src_n = single_clk_in ? k_n_in : c_n_in;
  // age since the last read load and cycles since reset
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      k_prev_reg <= 1'b1;
      rd_age_reg <= 6'h3f;
      up_cnt_reg <= 3'h0;
    end
    else
    begin
      k_prev_reg <= k_in;
      rd_age_reg <= rd_load ? 6'h0 : rd_age_reg + {5'h0, rd_age_reg != 6'h3f};
      up_cnt_reg <= up_cnt_reg + {2'h0, up_cnt_reg != 3'h7};
    end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_read_answer;
    rd_load |-> ##[4:40] $fell(dq_oe_n_out);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read load got no data");
  property p_fell_needs_read;
    $fell(dq_oe_n_out) |-> rd_age_reg <= 6'h28;
  endproperty
  a_fell_needs_read: assert property (p_fell_needs_read) else $error("drive without read");
  property p_oe_min_low;
    $fell(dq_oe_n_out) |-> !dq_oe_n_out [*5];
  endproperty
  a_oe_min_low: assert property (p_oe_min_low) else $error("burst cut short");
  property p_oe_release;
    $fell(dq_oe_n_out) |-> ##[6:24] $rose(dq_oe_n_out);
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("outputs not released");
  property p_dq_hold;
    dq_oe_n_out && $past(dq_oe_n_out) |-> $stable(dq_out);
  endproperty
  a_dq_hold: assert property (p_dq_hold) else $error("read data moved while idle");
  property p_echo_t;
    up_cnt_reg == 3'h7 |-> echo_clock_out == $past(echo_src, 3);
  endproperty
  a_echo_t: assert property (p_echo_t) else $error("true echo off its clock");
  property p_echo_n;
    up_cnt_reg == 3'h7 |-> echo_clock_n_out == $past(echo_src_n, 3);
  endproperty
  a_echo_n: assert property (p_echo_n) else $error("comp echo off its clock");
  property p_rst_quiet;
    up_cnt_reg < 3'h3 |-> dq_oe_n_out;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("drive right after reset");
  c_read: cover property ($fell(dq_oe_n_out));
  c_write: cover property (wr_load);
  c_mask: cover property (k_in && byte_write_sel_n_in != 4'h0);
endmodule
bind burst2_sram_host_port burst2_sram_host_port_sva i_sva (.clk_in(clk_in), .nrst_in(nrst_in),
  .k_in(k_in), .k_n_in(k_n_in), .c_in(c_in), .c_n_in(c_n_in),
  .load_strobe_n_in(load_strobe_n_in), .read_not_write_in(read_not_write_in),
  .byte_write_sel_n_in(byte_write_sel_n_in), .single_clk_in(single_clk_in), .dq_out(dq_out),
  .dq_oe_n_out(dq_oe_n_out), .echo_clock_out(echo_clock_out),
  .echo_clock_n_out(echo_clock_n_out));
